/* File: inc/dhc_defs.svh */
`ifndef DHC_DEFS_SVH
`define DHC_DEFS_SVH
// register byte offsets
`define DHC_CFG_OFF 12'h000
`define DHC_CTRL_OFF 12'h004
`define DHC_STAT_OFF 12'h008
`define DHC_ONTIME_OFF 12'h00C
`define DHC_RATE_OFF 12'h010
`define DHC_CH_BASE 12'h020
`define DHC_CH_STRIDE 12'h020
`define DHC_CH_MAX 12'h000
`define DHC_CH_SET 12'h004
`define DHC_CH_CNT 12'h008
`define DHC_CH_OLD 12'h00C
`define DHC_CH_OMODE 12'h010
// cfg fields
`define DHC_CFG_QUAD0 0
`define DHC_CFG_QUAD1 1
`define DHC_CFG_W32 2
`define DHC_CFG_NOASSERT 3
`define DHC_CFG_RATE 4
`define DHC_CFG_COMMKEEP 5
// ctrl fields (write: bit0/1 sw enable, 2/3 preset pulse, 4 output clear)
`define DHC_CTRL_SWEN0 0
`define DHC_CTRL_PRE0 2
`define DHC_CTRL_OCLR 4
`define DHC_CTRL_OUTDIS 5
// top counts
`define DHC_TOP16 32'h0000FFFF
`define DHC_TOP32 32'h7FFFFFFF
// timing
`define DHC_MS_NS 1000000
`define DHC_CLK_NS 10
`define DHC_MS_CYC (`DHC_MS_NS / `DHC_CLK_NS)
`define DHC_COMM_TIMEOUT_MS 100
`endif

/* File: inc/dhc_pkg.sv */
package dhc_pkg;
	// output trigger mode per switch
	typedef enum logic [2:0] {
		DHC_OM_SET,
		DHC_OM_SET_LATCH,
		DHC_OM_TERM,
		DHC_OM_TERM_LATCH,
		DHC_OM_TIMED_SET,
		DHC_OM_TIMED_TERM,
		DHC_OM_BOTH
	} dhc_omode_t;
endpackage

/* File: design/dhc_counter.sv */
`include "dhc_defs.svh"
module dhc_counter #(
	parameter int COMM_TIMEOUT_CYC = `DHC_COMM_TIMEOUT_MS * `DHC_MS_CYC,
	parameter int MS_CYC = `DHC_MS_CYC
) (
	// apb
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// field inputs, index per channel
	input wire logic [1:0] count_in,
	input wire logic [1:0] dir_in,
	input wire logic [1:0] hw_enable,
	input wire logic channel_one_hw_preset,
	input wire logic channel_two_hw_preset,
	input wire logic [1:0] out_reset_in,
	input wire logic fuse_blown,
	input wire logic field_power_ok,
	// switched outputs and indicators
	output logic channel_one_switch_a,
	output logic channel_one_switch_b,
	output logic channel_two_switch_a,
	output logic channel_two_switch_b,
	output logic fault_led,
	output logic active_led
);
	import dhc_pkg::*;

	logic [5:0] cfg_q;
	logic [1:0] swen_q;
	logic outdis_q;
	logic [13:0] ontime_q;
	logic [15:0] rate_ms_q;
	logic [31:0] max_q [2];
	logic [31:0] set_q [2];
	logic [31:0] cnt_q [2];
	logic [31:0] old_q [2];
	logic [31:0] rate_acc_q [2];
	logic [31:0] rate_val_q [2];
	dhc_omode_t omode_q [2][2];
	logic sw_q [2][2];
	logic [1:0] auto_en;
	logic [15:0] rate_tmr_q;
	logic [31:0] ms_div_q;
	logic [31:0] on_tmr_q;
	logic [31:0] comm_tmr_q;
	logic comm_ok_q;
	logic [2:0] pre_sw;
	logic wr;
	logic [31:0] top;
	logic [2:0] fs_q [12];
	logic [11:0] fld;
	logic [1:0] pa_q;
	logic [1:0] pb_q;

	assign wr = psel && penable && pwrite;
	// limitation: channel two shares channel one's width rules; width is module-wide
	assign top = cfg_q[`DHC_CFG_W32] ? `DHC_TOP32 : `DHC_TOP16;
	assign pre_sw = {1'b0, wr && paddr == `DHC_CTRL_OFF ? pwdata[`DHC_CTRL_PRE0 +: 2] : 2'b00};

	// three-stage sync; value moves once stages two and three agree
	logic [11:0] raw;
	assign raw = {field_power_ok, fuse_blown, out_reset_in, channel_two_hw_preset,
		channel_one_hw_preset, hw_enable, dir_in, count_in};
	genvar gi;
	generate
		for (gi = 0; gi < 12; gi++)
		begin : g_sync
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					fs_q[gi] <= 3'b000;
				else
					fs_q[gi] <= {fs_q[gi][1:0], raw[gi]};
			end
			logic flt_q;
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					flt_q <= 1'b0;
				else if (fs_q[gi][1] == fs_q[gi][2])
					flt_q <= fs_q[gi][2];
			end
			assign fld[gi] = flt_q;
		end
	endgenerate

	// apb register writes
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cfg_q <= 6'h00;
			swen_q <= 2'b00;
			outdis_q <= 1'b0;
			ontime_q <= 14'h0000;
			rate_ms_q <= 16'h0000;
		end
		else
		begin
			if (wr)
			begin
			unique case (paddr)
				`DHC_CFG_OFF: cfg_q <= pwdata[5:0];
				`DHC_CTRL_OFF:
				begin
					swen_q <= pwdata[`DHC_CTRL_SWEN0 +: 2];
					outdis_q <= pwdata[`DHC_CTRL_OUTDIS];
				end
				`DHC_ONTIME_OFF: ontime_q <= pwdata[13:0];
				`DHC_RATE_OFF: rate_ms_q <= pwdata[15:0];
				default:
				begin
				end
			endcase
		end
		// a preset or a new maximum re-arms the software enable
		for (int c = 0; c < 2; c++)
			if (auto_en[c])
				swen_q[c] <= 1'b1;
		end
	end

	// channel logic
	generate
		for (gi = 0; gi < 2; gi++)
		begin : g_ch
			logic [11:0] base;
			logic pre_hw;
			logic pre_hw_q;
			logic step;
			logic up;
			logic run;
			logic [31:0] nxt;
			logic hit_set;
			logic hit_max;
			assign base = 12'(`DHC_CH_BASE + gi * `DHC_CH_STRIDE);
			assign pre_hw = fld[6 + gi] && !pre_hw_q;
			// quad: direction from phase order, old A against new B
			assign up = cfg_q[gi] ? !(pa_q[gi] ^ fld[2 + gi]) : fld[2 + gi];
			assign auto_en[gi] = pre_hw || pre_sw[gi] || (wr && paddr == base + `DHC_CH_MAX);
			// quad counts each edge of A and B; pulse counts A rising edges
			assign step = cfg_q[gi] ? ((fld[gi] != pa_q[gi]) || (fld[2 + gi] != pb_q[gi]))
				: (fld[gi] && !pa_q[gi]);
			assign run = step && fld[4 + gi] && swen_q[gi];
			always_comb
			begin
				nxt = cnt_q[gi];
				if (up)
					nxt = (cnt_q[gi] >= max_q[gi]) ? 32'h0 : cnt_q[gi] + 32'h1;
				else
					nxt = (cnt_q[gi] == 32'h0) ? max_q[gi] : cnt_q[gi] - 32'h1;
			end
			assign hit_set = run && nxt == set_q[gi];
			assign hit_max = run && (up ? nxt == max_q[gi] : nxt == 32'h0);
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					pre_hw_q <= 1'b0;
					max_q[gi] <= 32'h0;
					set_q[gi] <= 32'h0;
					cnt_q[gi] <= 32'h0;
					old_q[gi] <= 32'h0;
					omode_q[gi][0] <= DHC_OM_SET;
					omode_q[gi][1] <= DHC_OM_TERM;
				end
				else
				begin
					pre_hw_q <= fld[6 + gi];
					if (wr && paddr == base + `DHC_CH_MAX)
					begin
						max_q[gi] <= pwdata & top;
						cnt_q[gi] <= up ? 32'h0 : pwdata & top;
					end
					else if (pre_hw || pre_sw[gi])
					begin
						// software and hardware same cycle resolve identically: one preset is taken
						old_q[gi] <= cnt_q[gi];
						cnt_q[gi] <= up ? 32'h0 : max_q[gi];
					end
					else if (run)
						cnt_q[gi] <= nxt;
					if (wr && paddr == base + `DHC_CH_SET)
						set_q[gi] <= pwdata & top;
					if (wr && paddr == base + `DHC_CH_OMODE)
					begin
						omode_q[gi][0] <= dhc_omode_t'(pwdata[2:0]);
						omode_q[gi][1] <= dhc_omode_t'(pwdata[6:4]);
					end
				end
			end
			// output switches
			for (genvar o = 0; o < 2; o++)
			begin : g_out
				logic trig;
				logic latch;
				logic timed;
				always_comb
				begin
					latch = 1'b0;
					timed = 1'b0;
					unique case (omode_q[gi][o])
						DHC_OM_SET: trig = hit_set;
						DHC_OM_SET_LATCH:
						begin
							trig = hit_set;
							latch = 1'b1;
						end
						DHC_OM_TERM: trig = hit_max;
						DHC_OM_TERM_LATCH:
						begin
							trig = hit_max;
							latch = 1'b1;
						end
						DHC_OM_TIMED_SET:
						begin
							trig = hit_set;
							timed = 1'b1;
						end
						DHC_OM_TIMED_TERM:
						begin
							trig = hit_max;
							timed = 1'b1;
						end
						default: trig = hit_set || hit_max;
					endcase
				end
				always_ff @(posedge pclk or negedge presetn)
				begin
					if (!presetn)
						sw_q[gi][o] <= 1'b0;
					else if (cfg_q[`DHC_CFG_NOASSERT] || cfg_q[`DHC_CFG_RATE])
						sw_q[gi][o] <= 1'b0;
					else if (fld[8 + gi] && !(trig && latch))
						sw_q[gi][o] <= 1'b0;
					else if (trig)
						sw_q[gi][o] <= 1'b1;
					else if (latch)
						sw_q[gi][o] <= sw_q[gi][o];
					else if (wr && paddr == `DHC_CTRL_OFF && pwdata[`DHC_CTRL_OCLR])
						sw_q[gi][o] <= 1'b0;
					else if (timed)
						sw_q[gi][o] <= sw_q[gi][o] && on_tmr_q != 32'h0;
					else if (run)
						sw_q[gi][o] <= 1'b0;
				end
			end
		end
	endgenerate

	// edge history for count and phase-b inputs
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pa_q <= 2'b00;
			pb_q <= 2'b00;
		end
		else
		begin
			pa_q <= fld[1:0];
			pb_q <= fld[3:2];
		end
	end

	// on-time timer, any set or terminal hit on either channel restarts it
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			on_tmr_q <= 32'h0;
		else if (g_ch[0].hit_set || g_ch[0].hit_max || g_ch[1].hit_set || g_ch[1].hit_max)
			on_tmr_q <= 32'(ontime_q) * 32'(MS_CYC);
		else if (on_tmr_q != 32'h0)
			on_tmr_q <= on_tmr_q - 32'h1;
	end

	// rate sample: count steps over a window of rate_ms_q ms, hold last completed value
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ms_div_q <= 32'h0;
			rate_tmr_q <= 16'h0000;
			for (int c = 0; c < 2; c++)
			begin
				rate_acc_q[c] <= 32'h0;
				rate_val_q[c] <= 32'h0;
			end
		end
		else if (cfg_q[`DHC_CFG_RATE])
		begin
			ms_div_q <= (ms_div_q >= 32'(MS_CYC - 1)) ? 32'h0 : ms_div_q + 32'h1;
			if (ms_div_q >= 32'(MS_CYC - 1))
				rate_tmr_q <= rate_tmr_q + 16'h0001;
			for (int c = 0; c < 2; c++)
			begin
				if (ms_div_q >= 32'(MS_CYC - 1) && rate_tmr_q + 16'h0001 >= rate_ms_q)
				begin
					rate_val_q[c] <= rate_acc_q[c];
					rate_acc_q[c] <= 32'h0;
				end
				else if (c == 0 ? g_ch[0].run : g_ch[1].run)
					rate_acc_q[c] <= rate_acc_q[c] + 32'h1;
			end
			if (ms_div_q >= 32'(MS_CYC - 1) && rate_tmr_q + 16'h0001 >= rate_ms_q)
				rate_tmr_q <= 16'h0000;
		end
	end

	// bus watchdog: any apb access counts as contact
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			comm_tmr_q <= 32'h0;
			comm_ok_q <= 1'b0;
		end
		else if (psel && penable)
		begin
			comm_tmr_q <= 32'h0;
			comm_ok_q <= 1'b1;
		end
		else if (comm_tmr_q >= 32'(COMM_TIMEOUT_CYC - 1))
			comm_ok_q <= 1'b0;
		else
			comm_tmr_q <= comm_tmr_q + 32'h1;
	end

	// output stage, all registered
	logic gate;
	assign gate = !outdis_q && (comm_ok_q || cfg_q[`DHC_CFG_COMMKEEP]);
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			channel_one_switch_a <= 1'b0;
			channel_one_switch_b <= 1'b0;
			channel_two_switch_a <= 1'b0;
			channel_two_switch_b <= 1'b0;
			fault_led <= 1'b0;
			active_led <= 1'b0;
		end
		else
		begin
			channel_one_switch_a <= gate && sw_q[0][0];
			channel_one_switch_b <= gate && sw_q[0][1];
			channel_two_switch_a <= gate && sw_q[1][0];
			channel_two_switch_b <= gate && sw_q[1][1];
			fault_led <= fld[10] || !fld[11];
			active_led <= comm_ok_q;
		end
	end

	// apb read, zero-wait
	logic [31:0] rd;
	always_comb
	begin
		rd = 32'h0;
		unique case (paddr)
			`DHC_CFG_OFF: rd = {26'h0, cfg_q};
			`DHC_CTRL_OFF: rd = {26'h0, outdis_q, 3'b000, swen_q};
			`DHC_STAT_OFF: rd = {29'h0, comm_ok_q, fault_led, 1'b0};
			`DHC_ONTIME_OFF: rd = {18'h0, ontime_q};
			`DHC_RATE_OFF: rd = {16'h0, rate_ms_q};
			default:
			begin
				for (int c = 0; c < 2; c++)
				begin
					if (paddr == 12'(`DHC_CH_BASE + c * `DHC_CH_STRIDE + `DHC_CH_MAX))
						rd = max_q[c];
					if (paddr == 12'(`DHC_CH_BASE + c * `DHC_CH_STRIDE + `DHC_CH_SET))
						rd = set_q[c];
					if (paddr == 12'(`DHC_CH_BASE + c * `DHC_CH_STRIDE + `DHC_CH_CNT))
						rd = cfg_q[`DHC_CFG_RATE] ? rate_val_q[c] : cnt_q[c];
					if (paddr == 12'(`DHC_CH_BASE + c * `DHC_CH_STRIDE + `DHC_CH_OLD))
						rd = old_q[c];
					if (paddr == 12'(`DHC_CH_BASE + c * `DHC_CH_STRIDE + `DHC_CH_OMODE))
						rd = {25'h0, omode_q[c][1], 1'b0, omode_q[c][0]};
				end
			end
		endcase
	end
	// data captured in setup, so access phase answers at once
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= 32'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			if (psel && !penable)
				prdata <= rd;
			pready <= psel && !penable;
			pslverr <= 1'b0;
		end
	end
endmodule

/* File: tb/dhc_ctrl_model.sv */
`include "dhc_defs.svh"
module dhc_ctrl_model (
	// bus
	input wire logic pclk,
	input wire logic [31:0] prdata,
	input wire logic pready,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata
);
	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
	end
	// request held until pready seen high at an edge
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] d);
		xfer(1'b0, a, 32'h00000000, d);
	endtask
	// writing the maximum already re-arms the software enable, so the set point goes in after the channel is let count
	task automatic load_chan(input int ch, input logic [31:0] mx, input logic [31:0] st);
		wr(12'(`DHC_CH_BASE + `DHC_CH_STRIDE * ch + `DHC_CH_MAX), mx);
		wr(12'(`DHC_CH_BASE + `DHC_CH_STRIDE * ch + `DHC_CH_SET), st);
	endtask
	task automatic enable_sw(input logic [1:0] m);
		wr(`DHC_CTRL_OFF, {30'h0, m});
	endtask
endmodule

/* File: tb/dhc_counter_monitor.sv */
module dhc_counter_monitor #(
	parameter int COMM_TIMEOUT_CYC = 100
) (
	// bus
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	// field
	input wire logic [1:0] out_reset_in,
	input wire logic fuse_blown,
	input wire logic field_power_ok,
	// outputs
	input wire logic channel_one_switch_a,
	input wire logic channel_one_switch_b,
	input wire logic channel_two_switch_a,
	input wire logic channel_two_switch_b,
	input wire logic fault_led,
	input wire logic active_led
);
	int idle_q;
	// saturates so a long quiet spell cannot wrap
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			idle_q <= 0;
		else if (psel)
			idle_q <= 0;
		else if (idle_q < COMM_TIMEOUT_CYC + 16)
			idle_q <= idle_q + 1;
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_done;
		psel && penable && pready;
	endsequence
	a_apb_zero_wait: assert property (s_setup ##1 psel && penable |-> pready)
		else $error("access phase not answered");
	a_fuse_fault: assert property (fuse_blown [*6] |-> fault_led)
		else $error("fuse fault not shown");
	a_power_fault: assert property (!field_power_ok [*6] |-> fault_led)
		else $error("power fault not shown");
	a_fault_clear: assert property ((!fuse_blown && field_power_ok) [*6] |-> !fault_led)
		else $error("fault shown without cause");
	a_reset_one: assert property (out_reset_in[0] [*8] |-> !channel_one_switch_a && !channel_one_switch_b)
		else $error("channel one outputs stay on");
	a_reset_two: assert property (out_reset_in[1] [*8] |-> !channel_two_switch_a && !channel_two_switch_b)
		else $error("channel two outputs stay on");
	a_active_on: assert property (s_setup ##1 s_done |-> ##[1:8] active_led)
		else $error("activity not shown");
	a_active_off: assert property (idle_q > COMM_TIMEOUT_CYC + 8 |-> !active_led)
		else $error("activity shown while bus quiet");
endmodule
bind dhc_counter dhc_counter_monitor #(.COMM_TIMEOUT_CYC(COMM_TIMEOUT_CYC)) u_mon (.pclk, .presetn, .psel,
	.penable, .pready, .out_reset_in, .fuse_blown, .field_power_ok, .channel_one_switch_a, .channel_one_switch_b,
	.channel_two_switch_a, .channel_two_switch_b, .fault_led, .active_led);

/* File: tb/test_dual_high_speed_counter.sv */
`include "dhc_defs.svh"
module test_dual_high_speed_counter;
	timeunit 1ns;
	timeprecision 1ps;
	import dhc_pkg::*;
	localparam int COMM_CYC = 200;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, fuse_blown, field_power_ok;
	logic channel_one_hw_preset, channel_two_hw_preset, fault_led, active_led;
	logic channel_one_switch_a, channel_one_switch_b, channel_two_switch_a, channel_two_switch_b;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd_v, c0;
	logic [1:0] count_in, dir_in, hw_enable, out_reset_in;
	int n_mismatch = 0;
	int checks_done = 0;
	dhc_counter #(.COMM_TIMEOUT_CYC(COMM_CYC), .MS_CYC(10)) DUT (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .count_in, .dir_in, .hw_enable, .channel_one_hw_preset,
		.channel_two_hw_preset, .out_reset_in, .fuse_blown, .field_power_ok, .channel_one_switch_a,
		.channel_one_switch_b, .channel_two_switch_a, .channel_two_switch_b, .fault_led, .active_led);
	dhc_ctrl_model ctrl (.pclk, .prdata, .pready, .psel, .penable, .pwrite, .paddr, .pwdata);
	initial
	begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	task automatic chk32(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("BAD %0t value %h expected %h", $time, g, e);
		end
	endtask
	task automatic chk1(input logic g, input logic e);
		checks_done++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("BAD %0t flag %b expected %b", $time, g, e);
		end
	endtask
	// slow pulses so the input synchronisers see every level
	task automatic pulse(input int ch, input int n);
		repeat (n)
		begin
			@(posedge pclk) count_in[ch] <= 1'b1;
			repeat (4) @(posedge pclk);
			count_in[ch] <= 1'b0;
			repeat (4) @(posedge pclk);
		end
		repeat (6) @(posedge pclk);
	endtask
	task automatic rdch(input int ch, input logic [11:0] off, input logic [31:0] e);
		ctrl.rd(12'(`DHC_CH_BASE + `DHC_CH_STRIDE * ch + off), rd_v);
		chk32(rd_v, e);
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial
	begin
		#400000;
		n_mismatch++;
		print_verdict();
	end
	initial
	begin
		presetn = 1'b0;
		count_in = 2'b00;
		dir_in = 2'b11;
		hw_enable = 2'b11;
		channel_one_hw_preset = 1'b0;
		channel_two_hw_preset = 1'b0;
		out_reset_in = 2'b00;
		fuse_blown = 1'b0;
		field_power_ok = 1'b1;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		ctrl.wr(`DHC_CFG_OFF, 32'h00000000);
		ctrl.load_chan(0, 32'h00000003, 32'h00000002);
		ctrl.enable_sw(2'b01);
		pulse(0, 2);
		rdch(0, `DHC_CH_CNT, 32'h00000002);
		@(posedge pclk) channel_one_hw_preset <= 1'b1;
		repeat (6) @(posedge pclk);
		channel_one_hw_preset <= 1'b0;
		repeat (6) @(posedge pclk);
		rdch(0, `DHC_CH_CNT, 32'h00000000);
		rdch(0, `DHC_CH_OLD, 32'h00000002);
		hw_enable[0] <= 1'b0;
		pulse(0, 1);
		rdch(0, `DHC_CH_CNT, 32'h00000000);
		hw_enable[0] <= 1'b1;
		pulse(0, 3);
		rdch(0, `DHC_CH_CNT, 32'h00000003);
		pulse(0, 1);
		rdch(0, `DHC_CH_CNT, 32'h00000000);
		dir_in[0] <= 1'b0;
		pulse(0, 1);
		rdch(0, `DHC_CH_CNT, 32'h00000003);
		pulse(0, 2);
		rdch(0, `DHC_CH_CNT, 32'h00000001);
		ctrl.wr(`DHC_CTRL_OFF, 32'h00000005);
		repeat (6) @(posedge pclk);
		rdch(0, `DHC_CH_CNT, 32'h00000003);
		rdch(0, `DHC_CH_OLD, 32'h00000001);
		// quadrature on channel two: one full cycle gives four edges, sign depends on phase order
		ctrl.wr(`DHC_CFG_OFF, 32'h00000002);
		ctrl.load_chan(1, 32'h00000064, 32'h00000032);
		ctrl.enable_sw(2'b11);
		ctrl.rd(12'(`DHC_CH_BASE + `DHC_CH_STRIDE + `DHC_CH_CNT), c0);
		repeat (2)
		begin
			@(posedge pclk) count_in[1] <= ~count_in[1];
			repeat (5) @(posedge pclk);
			dir_in[1] <= ~dir_in[1];
			repeat (5) @(posedge pclk);
		end
		repeat (6) @(posedge pclk);
		ctrl.rd(12'(`DHC_CH_BASE + `DHC_CH_STRIDE + `DHC_CH_CNT), rd_v);
		rd_v = (rd_v + 32'h00000065 - c0) % 32'h00000065;
		chk1(rd_v === 32'h00000004 || rd_v === 32'h00000061, 1'b1);
		chk1(active_led, 1'b1);
		fuse_blown <= 1'b1;
		repeat (8) @(posedge pclk);
		chk1(fault_led, 1'b1);
		fuse_blown <= 1'b0;
		field_power_ok <= 1'b0;
		repeat (8) @(posedge pclk);
		chk1(fault_led, 1'b1);
		field_power_ok <= 1'b1;
		repeat (8) @(posedge pclk);
		chk1(fault_led, 1'b0);
		out_reset_in <= 2'b11;
		repeat (8) @(posedge pclk);
		chk1(channel_one_switch_a | channel_one_switch_b | channel_two_switch_a | channel_two_switch_b, 1'b0);
		out_reset_in <= 2'b00;
		repeat (COMM_CYC + 20) @(posedge pclk);
		chk1(active_led, 1'b0);
		print_verdict();
	end
endmodule
